// File: tb_top.sv
// testbench for the voltage comparator control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
	$display("mismatch t=%0t got %0h exp %0h", $time, g, e); end end
module tb_top import vcc_pkg::*;;
	// ----------------------------------------
	// set-up
	// ----------------------------------------
	localparam int INT_CYC = (100 + 19) / 20;
	localparam int CORE_CYC = (60 + 19) / 20;
	typedef struct packed {
		logic [11:0] a;
		logic [31:0] pre;
		logic [31:0] w;
		logic [31:0] e;
	} vcc_row_t;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic cmp_above;
	vcc_ana_t ana;
	logic irq;
	logic [15:0] pin_mv [8] = '{default: 16'h0};
	logic [31:0] rdata;
	logic rerr;
	int errors = 0;
	int n_checks = 0;
	// address, value before, write, value after
	vcc_row_t rows [15] = '{
		'{VCC_OFS_POS_PIN, 32'h0, 32'h5, 32'h5},
		'{VCC_OFS_REF_SRC, 32'h0, 32'h7, 32'h0},
		'{VCC_OFS_REF_SRC, 32'h0, 32'h4, 32'h4},
		'{VCC_OFS_EXT_PIN, 32'h0, 32'h7, 32'h7},
		'{VCC_OFS_THRESH, 32'h0, 32'h2010, 32'h2010},
		'{VCC_OFS_MODE, 32'h0, 32'h3, 32'h0},
		'{VCC_OFS_MODE, 32'h0, 32'h102, 32'h102},
		'{VCC_OFS_DIFF_HYSTERESIS_ENABLE, 32'h0, 32'h1, 32'h1},
		'{VCC_OFS_LINKS, 32'h0, 32'h1f, 32'h1f},
		'{VCC_OFS_IEN, 32'h0, 32'hf, 32'hf},
		'{VCC_OFS_IEN_CLR, 32'hf, 32'h5, 32'ha},
		'{VCC_OFS_IEN_SET, 32'ha, 32'h1, 32'hb},
		'{VCC_OFS_RESULT, 32'h0, 32'h1, 32'h0},
		'{VCC_OFS_READY, 32'h0, 32'h1, 32'h1},
		'{12'h7fc, 32'h0, 32'hffff, 32'h0}
	};
	always #10 clk = ~clk;
	vcc_top #(.T_INTREF_NS(100), .T_CORE_NS(60)) dut_u (
		.REF_CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .CMP_ABOVE(cmp_above),
		.ANA_CTRL(ana), .IRQ(irq)
	);
	vcc_analog_model ana_u (
		.clk(clk), .ana(ana), .pin_mv(pin_mv), .above(cmp_above)
	);
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : tally_and_finish
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			errors++;
			tally_and_finish();
		end
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rdata, e)
	endtask : rd
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	// edges from the start write to the interrupt line rising
	task automatic wait_irq(input int exp);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (irq !== 1'b1 && n < 50);
		`CHK(n, exp)
		if (n >= 50) begin
			tally_and_finish();
		end
	endtask : wait_irq
	task automatic clr_flags;
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, VCC_OFS_READY + 12'(k * 4), 32'h0);
		end
	endtask : clr_flags
	task automatic done(input string s);
		$display("test %s done", s);
	endtask : done
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		foreach (rows[i]) begin
			rd(rows[i].a, rows[i].pre);
			apb(1'b1, rows[i].a, rows[i].w);
			rd(rows[i].a, rows[i].e);
		end
		`CHK(rerr, 1'b1)
		apb(1'b1, VCC_OFS_LINKS, 32'h0);
		apb(1'b1, VCC_OFS_READY, 32'h0);
		apb(1'b1, VCC_OFS_IEN, 32'h1);
		done("registers");
		apb(1'b1, VCC_OFS_MODE, 32'h1);
		apb(1'b1, VCC_OFS_REF_SRC, 32'h0);
		pin_mv[5] <= 16'hc8;
		apb(1'b1, VCC_OFS_ENABLE, 32'h1);
		step(2);
		`CHK(ana.pins_connected, 1'b1)
		`CHK(ana.core_on, 1'b0)
		apb(1'b1, VCC_OFS_START, 32'h1);
		wait_irq(INT_CYC + 1);
		done("start");
		apb(1'b1, VCC_OFS_READY, 32'h0);
		pin_mv[5] <= 16'h2bc;
		step(4);
		rd(VCC_OFS_UP, 32'h1);
		rd(VCC_OFS_CROSS, 32'h1);
		`CHK(ana.ladder_level, 6'h10)
		clr_flags();
		pin_mv[5] <= 16'h1c2;
		step(4);
		rd(VCC_OFS_CROSS, 32'h0);
		pin_mv[5] <= 16'hc8;
		step(4);
		rd(VCC_OFS_DOWN, 32'h1);
		rd(VCC_OFS_CROSS, 32'h1);
		rd(VCC_OFS_UP, 32'h0);
		`CHK(ana.ladder_level, 6'h20)
		apb(1'b1, VCC_OFS_SAMPLE, 32'h1);
		rd(VCC_OFS_RESULT, 32'h0);
		pin_mv[5] <= 16'h2bc;
		step(3);
		apb(1'b1, VCC_OFS_SAMPLE, 32'h1);
		rd(VCC_OFS_RESULT, 32'h1);
		apb(1'b1, VCC_OFS_DIFF_HYSTERESIS_ENABLE, 32'h0);
		rd(VCC_OFS_DIFF_HYSTERESIS_ENABLE, 32'h1);
		`CHK(ana.diff_hysteresis_enable_en, 1'b0)
		done("single-ended");
		apb(1'b1, VCC_OFS_STOP, 32'h1);
		step(2);
		`CHK(ana.core_on, 1'b0)
		clr_flags();
		step(6);
		rd(VCC_OFS_CROSS, 32'h0);
		done("stop");
		apb(1'b1, VCC_OFS_ENABLE, 32'h0);
		apb(1'b1, VCC_OFS_MODE, 32'h101);
		apb(1'b1, VCC_OFS_DIFF_HYSTERESIS_ENABLE, 32'h1);
		pin_mv[7] <= 16'h5dc;
		pin_mv[5] <= 16'h3e8;
		apb(1'b1, VCC_OFS_ENABLE, 32'h1);
		step(3);
		apb(1'b1, VCC_OFS_START, 32'h1);
		wait_irq(CORE_CYC + 1);
		clr_flags();
		pin_mv[5] <= 16'h604;
		step(4);
		rd(VCC_OFS_UP, 32'h0);
		pin_mv[5] <= 16'h618;
		step(4);
		rd(VCC_OFS_UP, 32'h1);
		done("differential");
		apb(1'b1, VCC_OFS_IEN_SET, 32'h4);
		step(2);
		`CHK(irq, 1'b1)
		apb(1'b1, VCC_OFS_IEN_CLR, 32'h4);
		step(2);
		`CHK(irq, 1'b0)
		rd(VCC_OFS_UP, 32'h1);
		done("interrupt");
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire

// File: vcc_analog_model.sv
// analog front model: input pins, references, ladder and core decision
`timescale 1ns/10ps
`default_nettype none
module vcc_analog_model import vcc_pkg::*; #(
	parameter int SUPPLY_MV = 3300,
	parameter int DIFF_HYSTERESIS_ENABLE_MV = 100
) (
	// clock
	input wire logic clk,
	// control from the block and pin levels in millivolts
	input wire vcc_ana_t ana,
	input wire logic [15:0] pin_mv [8],
	// core decision
	output logic above
);
	int vp;
	int vn;
	int vref;
	logic above_r = 1'b0;
	logic tgl_r = 1'b0;
	// decision follows the inputs at once; a sampled decision with the
	// registered ladder level would ring inside the hysteresis band
	assign above = (ana.pins_connected && ana.core_on) ? (vp > vn) : tgl_r;
	always_comb begin
		vp = int'(pin_mv[ana.positive_input_pin]);
		case (ana.reference_source)
			VCC_REF_INT_1V2: vref = 1200;
			VCC_REF_INT_1V8: vref = 1800;
			VCC_REF_INT_2V4: vref = 2400;
			VCC_REF_SUPPLY: vref = SUPPLY_MV;
			default: vref = int'(pin_mv[ana.external_reference_pin]);
		endcase
		if (ana.diff_mode) begin
			vn = int'(pin_mv[ana.external_reference_pin]);
		end else begin
			vn = vref * int'(ana.ladder_level) / 64;
		end
		// hysteresis band is half below and half above the negative input
		if (ana.diff_hysteresis_enable_en) begin
			vn = above_r ? vn - DIFF_HYSTERESIS_ENABLE_MV / 2 : vn + DIFF_HYSTERESIS_ENABLE_MV / 2;
		end
	end
	// pins not acquired or core off: no valid decision, so it wobbles
	always @(posedge clk) begin
		tgl_r <= !tgl_r;
		above_r <= above;
	end
endmodule : vcc_analog_model
`default_nettype wire

// File: vcc_pkg.sv
// constants and types shared by the voltage comparator control block
`default_nettype none
package vcc_pkg;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam int VCC_AW = 12;
	localparam logic [11:0] VCC_OFS_START = 12'h000;
	localparam logic [11:0] VCC_OFS_STOP = 12'h004;
	localparam logic [11:0] VCC_OFS_SAMPLE = 12'h008;
	localparam logic [11:0] VCC_OFS_READY = 12'h100;
	localparam logic [11:0] VCC_OFS_DOWN = 12'h104;
	localparam logic [11:0] VCC_OFS_UP = 12'h108;
	localparam logic [11:0] VCC_OFS_CROSS = 12'h10c;
	localparam logic [11:0] VCC_OFS_LINKS = 12'h200;
	localparam logic [11:0] VCC_OFS_IEN = 12'h300;
	localparam logic [11:0] VCC_OFS_IEN_SET = 12'h304;
	localparam logic [11:0] VCC_OFS_IEN_CLR = 12'h308;
	localparam logic [11:0] VCC_OFS_RESULT = 12'h400;
	localparam logic [11:0] VCC_OFS_ENABLE = 12'h500;
	localparam logic [11:0] VCC_OFS_POS_PIN = 12'h504;
	localparam logic [11:0] VCC_OFS_REF_SRC = 12'h508;
	localparam logic [11:0] VCC_OFS_EXT_PIN = 12'h50c;
	localparam logic [11:0] VCC_OFS_THRESH = 12'h530;
	localparam logic [11:0] VCC_OFS_MODE = 12'h534;
	localparam logic [11:0] VCC_OFS_DIFF_HYSTERESIS_ENABLE = 12'h538;

	// ------------------------------------------------------------
	// field layout
	// ------------------------------------------------------------
	localparam int VCC_LADDER_W = 6;
	localparam int VCC_TH_LO_LSB = 0;
	localparam int VCC_TH_HI_LSB = 8;
	localparam int VCC_MODE_SPEED_LSB = 0;
	localparam int VCC_MODE_DIFF_BIT = 8;
	localparam int VCC_LNK_RDY_SAMPLE = 0;
	localparam int VCC_LNK_RDY_STOP = 1;
	localparam int VCC_LNK_DOWN_STOP = 2;
	localparam int VCC_LNK_UP_STOP = 3;
	localparam int VCC_LNK_CROSS_STOP = 4;
	localparam int VCC_LNK_W = 5;
	localparam int VCC_IEN_READY = 0;
	localparam int VCC_IEN_DOWN = 1;
	localparam int VCC_IEN_UP = 2;
	localparam int VCC_IEN_CROSS = 3;
	localparam int VCC_IEN_W = 4;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int VCC_CLK_NS = 20;
	localparam int VCC_T_INTREF_NS = 20000;
	localparam int VCC_T_CORE_NS = 5000;

	// ------------------------------------------------------------
	// enumerations and carriers
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		VCC_REF_INT_1V2 = 3'h0,
		VCC_REF_INT_1V8 = 3'h1,
		VCC_REF_INT_2V4 = 3'h2,
		VCC_REF_SUPPLY = 3'h3,
		VCC_REF_EXT_PIN = 3'h4
	} vcc_ref_t;

	typedef enum logic [1:0] {
		VCC_SPD_LOW_POWER = 2'h0,
		VCC_SPD_NORMAL = 2'h1,
		VCC_SPD_HIGH_SPEED = 2'h2
	} vcc_speed_t;

	typedef enum logic [1:0] {
		VCC_ST_OFF = 2'b00,
		VCC_ST_WARMUP = 2'b01,
		VCC_ST_RUN = 2'b10
	} vcc_state_t;

	typedef struct packed {
		logic pins_connected;
		logic core_on;
		logic [2:0] positive_input_pin;
		logic [2:0] external_reference_pin;
		vcc_ref_t reference_source;
		logic [5:0] ladder_level;
		logic diff_mode;
		vcc_speed_t speed;
		logic diff_hysteresis_enable_en;
	} vcc_ana_t;

endpackage : vcc_pkg
`default_nettype wire

// File: vcc_top.sv
// voltage comparator control: apb registers, start/stop, events, ladder
`timescale 1ns/10ps
`default_nettype none
module vcc_top import vcc_pkg::*; #(
	parameter int T_INTREF_NS = VCC_T_INTREF_NS,
	parameter int T_CORE_NS = VCC_T_CORE_NS
) (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic ARST_N,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [VCC_AW-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// analog core
	input wire logic CMP_ABOVE,
	output vcc_ana_t ANA_CTRL,
	// interrupt
	output logic IRQ
);

	// ------------------------------------------------------------
	// timing counts
	// ------------------------------------------------------------
	localparam int INTREF_CYC = (T_INTREF_NS + VCC_CLK_NS - 1) / VCC_CLK_NS;
	localparam int CORE_CYC = (T_CORE_NS + VCC_CLK_NS - 1) / VCC_CLK_NS;
	localparam int CW = $clog2(INTREF_CYC + CORE_CYC + 2);
	localparam logic [CW-1:0] INTREF_LD = CW'(INTREF_CYC - 1);
	localparam logic [CW-1:0] CORE_LD = CW'(CORE_CYC - 1);

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	vcc_state_t state_r;
	logic [CW-1:0] cnt_r;
	logic enable_r;
	logic [2:0] pos_pin_r;
	logic [2:0] ext_pin_r;
	vcc_ref_t ref_src_r;
	logic [5:0] th_lo_r;
	logic [5:0] th_hi_r;
	logic diff_r;
	vcc_speed_t speed_r;
	logic diff_hysteresis_enable_r;
	logic [VCC_LNK_W-1:0] links_r;
	logic [VCC_IEN_W-1:0] ien_r;
	logic [VCC_IEN_W-1:0] flags_r;
	logic result_r;
	logic above_prev_r;
	logic [31:0] prdata_r;
	logic slverr_r;
	logic irq_r;
	vcc_ana_t ana_r;

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	logic wr;
	logic setup;
	logic [31:0] rd_nxt;
	logic hit_nxt;

	assign setup = PSEL & ~PENABLE;
	assign wr = PSEL & PENABLE & PWRITE;
	assign PREADY = PENABLE;
	assign PRDATA = prdata_r;
	assign PSLVERR = slverr_r;
	assign IRQ = irq_r;
	assign ANA_CTRL = ana_r;

	function automatic logic wr_at(input logic [VCC_AW-1:0] ofs);
		wr_at = wr && (PADDR == ofs);
	endfunction : wr_at

	// ------------------------------------------------------------
	// tasks, shortcuts and events
	// ------------------------------------------------------------
	logic start_req;
	logic stop_req;
	logic sample_req;
	logic ev_ready;
	logic ev_up;
	logic ev_down;
	logic ev_cross;
	logic stop_all;
	logic sample_all;
	logic use_intref;
	logic [VCC_IEN_W-1:0] ev_vec;

	assign start_req = wr_at(VCC_OFS_START) && PWDATA[0];
	assign stop_req = wr_at(VCC_OFS_STOP) && PWDATA[0];
	assign sample_req = wr_at(VCC_OFS_SAMPLE) && PWDATA[0];
	assign ev_ready = (state_r == VCC_ST_WARMUP) && (cnt_r == '0)
		&& enable_r && !stop_req;
	// a crossing is only seen on a running core with a valid output
	assign ev_up = (state_r == VCC_ST_RUN) && CMP_ABOVE
		&& !above_prev_r;
	assign ev_down = (state_r == VCC_ST_RUN) && !CMP_ABOVE
		&& above_prev_r;
	assign ev_cross = ev_up | ev_down;
	assign stop_all = stop_req
		| (ev_ready & links_r[VCC_LNK_RDY_STOP])
		| (ev_down & links_r[VCC_LNK_DOWN_STOP])
		| (ev_up & links_r[VCC_LNK_UP_STOP])
		| (ev_cross & links_r[VCC_LNK_CROSS_STOP]);
	assign sample_all = sample_req | (ev_ready & links_r[VCC_LNK_RDY_SAMPLE]);
	// the ladder only draws on an internal reference in single-ended mode
	assign use_intref = !diff_r && (ref_src_r == VCC_REF_INT_1V2
		|| ref_src_r == VCC_REF_INT_1V8 || ref_src_r == VCC_REF_INT_2V4);
	assign ev_vec = {ev_cross, ev_up, ev_down, ev_ready};

	// ------------------------------------------------------------
	// run state
	// ------------------------------------------------------------
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state_r <= VCC_ST_OFF;
			cnt_r <= '0;
		end else if (!enable_r) begin
			state_r <= VCC_ST_OFF;
			cnt_r <= '0;
		end else begin
			case (state_r)
				VCC_ST_OFF: begin
					if (start_req) begin
						state_r <= VCC_ST_WARMUP;
						cnt_r <= use_intref ? INTREF_LD : CORE_LD;
					end
				end
				VCC_ST_WARMUP: begin
					if (stop_all) begin
						state_r <= VCC_ST_OFF;
					end else if (cnt_r == '0) begin
						state_r <= VCC_ST_RUN;
					end else begin
						cnt_r <= cnt_r - CW'(1);
					end
				end
				VCC_ST_RUN: begin
					if (stop_all) begin
						state_r <= VCC_ST_OFF;
					end
				end
				default: begin
					state_r <= VCC_ST_OFF;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// output tracking and sample
	// ------------------------------------------------------------
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			above_prev_r <= 1'b0;
		end else begin
			above_prev_r <= CMP_ABOVE;
		end
	end

	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			result_r <= 1'b0;
		end else if (sample_all) begin
			result_r <= CMP_ABOVE;
		end
	end

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			enable_r <= 1'b0;
			pos_pin_r <= '0;
			ext_pin_r <= '0;
			ref_src_r <= VCC_REF_INT_1V2;
			th_lo_r <= '0;
			th_hi_r <= '0;
			diff_r <= 1'b0;
			speed_r <= VCC_SPD_LOW_POWER;
			links_r <= '0;
		end else begin
			if (wr_at(VCC_OFS_ENABLE)) begin
				enable_r <= PWDATA[0];
			end
			if (wr_at(VCC_OFS_POS_PIN)) begin
				pos_pin_r <= PWDATA[2:0];
			end
			if (wr_at(VCC_OFS_EXT_PIN)) begin
				ext_pin_r <= PWDATA[2:0];
			end
			// undefined source codes are dropped, keeping the last legal one
			if (wr_at(VCC_OFS_REF_SRC) && PWDATA[2:0] <= VCC_REF_EXT_PIN) begin
				ref_src_r <= vcc_ref_t'(PWDATA[2:0]);
			end
			if (wr_at(VCC_OFS_THRESH)) begin
				th_lo_r <= PWDATA[VCC_TH_LO_LSB +: VCC_LADDER_W];
				th_hi_r <= PWDATA[VCC_TH_HI_LSB +: VCC_LADDER_W];
			end
			if (wr_at(VCC_OFS_MODE)) begin
				diff_r <= PWDATA[VCC_MODE_DIFF_BIT];
				if (PWDATA[VCC_MODE_SPEED_LSB +: 2] <= VCC_SPD_HIGH_SPEED) begin
					speed_r <= vcc_speed_t'(PWDATA[VCC_MODE_SPEED_LSB +: 2]);
				end
			end
			if (wr_at(VCC_OFS_LINKS)) begin
				links_r <= PWDATA[VCC_LNK_W-1:0];
			end
		end
	end

	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			diff_hysteresis_enable_r <= 1'b0;
		end else if (wr_at(VCC_OFS_DIFF_HYSTERESIS_ENABLE) && diff_r) begin
			diff_hysteresis_enable_r <= PWDATA[0];
		end
	end

	// ------------------------------------------------------------
	// event flags and interrupt enables
	// ------------------------------------------------------------
	logic [VCC_IEN_W-1:0] flag_wr;

	assign flag_wr = {wr_at(VCC_OFS_CROSS), wr_at(VCC_OFS_UP),
		wr_at(VCC_OFS_DOWN), wr_at(VCC_OFS_READY)};

	genvar gi;
	generate
		for (gi = 0; gi < VCC_IEN_W; gi++) begin : g_flag
			// a new event beats a clearing write in the same cycle
			always_ff @(posedge REF_CLK or negedge ARST_N) begin
				if (!ARST_N) begin
					flags_r[gi] <= 1'b0;
				end else if (ev_vec[gi]) begin
					flags_r[gi] <= 1'b1;
				end else if (flag_wr[gi]) begin
					flags_r[gi] <= PWDATA[0];
				end
			end
		end
	endgenerate

	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ien_r <= '0;
		end else if (wr_at(VCC_OFS_IEN)) begin
			ien_r <= PWDATA[VCC_IEN_W-1:0];
		end else if (wr_at(VCC_OFS_IEN_SET)) begin
			ien_r <= ien_r | PWDATA[VCC_IEN_W-1:0];
		end else if (wr_at(VCC_OFS_IEN_CLR)) begin
			ien_r <= ien_r & ~PWDATA[VCC_IEN_W-1:0];
		end
	end

	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(flags_r & ien_r);
		end
	end

	// ------------------------------------------------------------
	// analog control
	// ------------------------------------------------------------
	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ana_r <= '0;
		end else begin
			ana_r.pins_connected <= enable_r;
			ana_r.core_on <= enable_r && (state_r != VCC_ST_OFF);
			ana_r.positive_input_pin <= pos_pin_r;
			ana_r.external_reference_pin <= ext_pin_r;
			ana_r.reference_source <= ref_src_r;
			// hysteresis: drop to the lower level once the output is above
			ana_r.ladder_level <= CMP_ABOVE ? th_lo_r : th_hi_r;
			ana_r.diff_mode <= diff_r;
			ana_r.speed <= speed_r;
			ana_r.diff_hysteresis_enable_en <= diff_r & diff_hysteresis_enable_r;
		end
	end

	// ------------------------------------------------------------
	// read mux, captured in the setup phase
	// ------------------------------------------------------------
	always_comb begin
		rd_nxt = '0;
		hit_nxt = 1'b1;
		case (PADDR)
			VCC_OFS_START, VCC_OFS_STOP, VCC_OFS_SAMPLE: rd_nxt = '0;
			VCC_OFS_READY: rd_nxt[0] = flags_r[VCC_IEN_READY];
			VCC_OFS_DOWN: rd_nxt[0] = flags_r[VCC_IEN_DOWN];
			VCC_OFS_UP: rd_nxt[0] = flags_r[VCC_IEN_UP];
			VCC_OFS_CROSS: rd_nxt[0] = flags_r[VCC_IEN_CROSS];
			VCC_OFS_LINKS: rd_nxt[VCC_LNK_W-1:0] = links_r;
			VCC_OFS_IEN, VCC_OFS_IEN_SET, VCC_OFS_IEN_CLR: begin
				rd_nxt[VCC_IEN_W-1:0] = ien_r;
			end
			VCC_OFS_RESULT: rd_nxt[0] = result_r;
			VCC_OFS_ENABLE: rd_nxt[0] = enable_r;
			VCC_OFS_POS_PIN: rd_nxt[2:0] = pos_pin_r;
			VCC_OFS_REF_SRC: rd_nxt[2:0] = ref_src_r;
			VCC_OFS_EXT_PIN: rd_nxt[2:0] = ext_pin_r;
			VCC_OFS_THRESH: begin
				rd_nxt[VCC_TH_LO_LSB +: VCC_LADDER_W] = th_lo_r;
				rd_nxt[VCC_TH_HI_LSB +: VCC_LADDER_W] = th_hi_r;
			end
			VCC_OFS_MODE: begin
				rd_nxt[VCC_MODE_SPEED_LSB +: 2] = speed_r;
				rd_nxt[VCC_MODE_DIFF_BIT] = diff_r;
			end
			VCC_OFS_DIFF_HYSTERESIS_ENABLE: rd_nxt[0] = diff_hysteresis_enable_r;
			default: hit_nxt = 1'b0;
		endcase
	end

	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			prdata_r <= '0;
			slverr_r <= 1'b0;
		end else if (setup) begin
			prdata_r <= PWRITE ? 32'h0000_0000 : rd_nxt;
			slverr_r <= !hit_nxt;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	logic [CW-1:0] wait_r;
	logic [CW-1:0] want_r;

	always_ff @(posedge REF_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			wait_r <= '0;
			want_r <= '0;
		end else if (state_r == VCC_ST_OFF) begin
			wait_r <= '0;
			want_r <= use_intref ? INTREF_LD : CORE_LD;
		end else if (state_r == VCC_ST_WARMUP) begin
			wait_r <= wait_r + CW'(1);
		end
	end

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!ARST_N);

	a_start_warmup: assert property (enable_r && state_r == VCC_ST_OFF
		&& start_req |=> state_r == VCC_ST_WARMUP)
		else $error("start not taken");
	a_stop_halts: assert property (enable_r && state_r == VCC_ST_RUN
		&& stop_req |=> state_r == VCC_ST_OFF)
		else $error("stop not taken");
	a_ready_delay: assert property (ev_ready |-> wait_r == want_r)
		else $error("ready delay wrong");
	a_quiet_stopped: assert property (state_r != VCC_ST_RUN
		|=> !flags_r[VCC_IEN_CROSS] || $past(flags_r[VCC_IEN_CROSS])
		|| $past(flag_wr[VCC_IEN_CROSS]))
		else $error("crossing while stopped");
	a_up_cross: assert property (state_r == VCC_ST_RUN && !above_prev_r
		&& CMP_ABOVE |=> flags_r[VCC_IEN_UP] && flags_r[VCC_IEN_CROSS])
		else $error("up crossing lost");
	a_down_cross: assert property (state_r == VCC_ST_RUN && above_prev_r
		&& !CMP_ABOVE |=> flags_r[VCC_IEN_DOWN] && flags_r[VCC_IEN_CROSS])
		else $error("down crossing lost");
	a_sample_copy: assert property (sample_req
		|=> result_r == $past(CMP_ABOVE))
		else $error("sample not copied");
	a_ladder_pick: assert property (1'b1 |=> ana_r.ladder_level
		== ($past(CMP_ABOVE) ? $past(th_lo_r) : $past(th_hi_r)))
		else $error("ladder level wrong");
	a_diff_hysteresis_enable_ignored: assert property (!diff_r |=> $stable(diff_hysteresis_enable_r)
		&& !ana_r.diff_hysteresis_enable_en)
		else $error("hysteresis used in single-ended");
	a_flag_sticky: assert property (flags_r[VCC_IEN_UP]
		&& !flag_wr[VCC_IEN_UP] |=> flags_r[VCC_IEN_UP])
		else $error("flag dropped");
	a_ien_set: assert property (wr_at(VCC_OFS_IEN_SET) |=> ien_r
		== ($past(ien_r) | $past(PWDATA[VCC_IEN_W-1:0])))
		else $error("enable set wrong");
	a_pins_enable: assert property (enable_r ##1 enable_r
		|-> ana_r.pins_connected)
		else $error("pins not connected");

endmodule : vcc_top
`default_nettype wire
